// ### rtl/link_align_pkg.sv
// Constants and types shared by the serial link character alignment receiver.
package link_align_pkg;
	localparam logic [3:0]  BIT_LAST     = 4'h9;
	localparam logic [3:0]  BIT_RST      = 4'h0;
	localparam logic [1:0]  LANE_RST     = 2'h0;
	localparam logic [1:0]  LANE_LAST    = 2'h3;
	localparam logic [6:0]  COMMA_NEG    = 7'h1F;
	localparam logic [6:0]  COMMA_POS    = 7'h60;
	localparam logic [5:0]  K28_SIX      = 6'h0F;
	localparam logic [7:0]  K28_5        = 8'hBC;
	localparam logic [7:0]  K28_3        = 8'h7C;
	localparam logic [5:0]  SIX_ONLY_NEG = 6'h38;
	localparam logic [5:0]  SIX_ONLY_POS = 6'h07;
	localparam logic [3:0]  FOUR_ONLY_NEG = 4'hC;
	localparam logic [3:0]  FOUR_ONLY_POS = 4'h3;
	localparam logic [3:0]  FOUR_ALT7    = 4'h7;
	localparam logic [5:0]  SIX_TBL [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B,
		6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0]  FOUR_TBL [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [31:0] CRC_POLY     = 32'h04C11DB7;
	localparam logic [31:0] COUNT_STEP   = 32'h00000004;
	localparam logic [3:0]  WIDX_RST     = 4'h0;
	localparam int          FIFO_W       = 34;
	localparam int          FIFO_DEPTH   = 4;
	typedef enum logic {FR_IDLE, FR_BODY} frame_state_t;
endpackage

// ### rtl/serial_link_char_alignment.sv
// Comma alignment, 8b/10b checking, Dword assembly, framing and DMA phase tracking of the link receiver.
`timescale 1ns/1ps
`default_nettype none

module dword_fifo #(
	parameter int W     = 34,
	parameter int DEPTH = 4
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0]   cnt_reg;
	logic [PW:0]   cnt_next;
	wire           do_wr = in_valid && in_ready;
	wire           do_rd = out_valid && out_ready;

	assign cnt_next = cnt_reg + (PW+1)'(do_wr) - (PW+1)'(do_rd);
	assign out_data = mem[rd_ptr_reg];

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			in_ready   <= 1'b1;
			out_valid  <= 1'b0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + PW'(do_wr);
			rd_ptr_reg <= rd_ptr_reg + PW'(do_rd);
			cnt_reg    <= cnt_next;
			in_ready   <= cnt_next != (PW+1)'(DEPTH);
			out_valid  <= cnt_next != '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (do_wr)
			mem[wr_ptr_reg] <= in_data;
	end
endmodule // dword_fifo

// How it works
// R1: A comma inside a K28.5 character resets the character boundary to it.
// R2: Bit times are added or dropped only when realigning on alignment characters.
// R3: A running disparity error flags a code violation.
// R4: A ten-bit code with no data or control meaning flags a code violation.
// R5: Lane 0 control characters other than K28.5 or K28.3 are violations.
// R6: Any control character in lanes 1 to 3 is a violation.
// R7: K28.5 is the only comma character and only alignment primitives carry it.
// R8: The comma is 0011111 or 1100000 in the first seven encoded bits.
// R9: Each frame ends with a 32-bit CRC Dword just before end-of-frame.
// R10: Dword bit 0 and byte 0 are least significant.
// R11: After the comma, Dwords are counted from the comma character as lane 0.
// R12: Encoded bit a is bit 0 and arrives first; bit j is bit 9.
// R13: A primitive is a control character in byte 0 and data in bytes 1 to 3.
// R14: A frame is start primitive, payload, CRC, end primitive, in that order.
// R15: The DMA data phase runs from DMA Setup until count runs out or error.
// R16: Each character carries a flag choosing the data or the control code set.
// R17: Slipping and alignment happen in the bit shift stage, ahead of Dword assembly.
// R18: A code violation is reported together with the Dword it was found in.
module serial_link_char_alignment #(
	parameter logic [31:0] SOF_PRIM       = 32'h0000017C,
	parameter logic [31:0] EOF_PRIM       = 32'h0000027C,
	parameter logic [7:0]  DMA_SETUP_TYPE = 8'h01,
	parameter logic [3:0]  COUNT_IDX      = 4'h5,
	parameter logic [31:0] CRC_INIT       = 32'h00000000
) (
	input  wire logic                         mclk,
	input  wire logic                         sys_rst,
	input  wire logic                         bit_valid,
	input  wire logic                         bit_in,
	input  wire logic                         shadow_err,
	input  wire logic                         out_ready,
	output logic                              out_valid,
	output logic [31:0]                       out_dword,
	output logic                              out_ctrl,
	output logic                              out_code_err,
	output logic                              in_accept,
	output logic                              overflow,
	output logic                              sync_ok,
	output logic                              slip_pulse,
	output logic                              frame_start,
	output logic                              frame_end,
	output logic                              crc_err,
	output logic                              frame_err,
	output logic                              dma_phase
);
	import link_align_pkg::*;

	// Returns {legal, control flag, HGF, EDCBA} for one encoded character.
	function automatic logic [9:0] dec_char(input logic [0:9] c);
		logic [5:0] s;
		logic [3:0] f;
		logic       ok6;
		logic       ok4;
		logic       k;
		logic [4:0] x;
		logic [2:0] y;
		s   = c[0:5];
		f   = c[6:9];
		ok6 = 1'b0;
		ok4 = 1'b0;
		x   = 5'h00;
		y   = 3'h0;
		k   = (s == K28_SIX) || (s == ~K28_SIX);
		for (int i = 0; i < 32; i++)
			if (s == SIX_TBL[i] || (s == ~SIX_TBL[i] && ($countones(SIX_TBL[i]) != 3 || i == 7)))
			begin
				ok6 = 1'b1;
				x   = 5'(i);
			end
		if (k)
		begin
			ok6 = 1'b1;
			x   = 5'h1C;
		end
		for (int j = 0; j < 8; j++)
			if (f == FOUR_TBL[j] || (f == ~FOUR_TBL[j] && (k || $countones(FOUR_TBL[j]) != 2 || j == 3)))
			begin
				ok4 = 1'b1;
				y   = 3'(j);
			end
		if (f == FOUR_ALT7 || f == ~FOUR_ALT7)
		begin
			ok4 = 1'b1;
			y   = 3'h7;
		end
		return {ok6 && ok4, k, y, x};
	endfunction

	// Returns {disparity error, running disparity after}; rd high means positive.
	function automatic logic [1:0] rd_check(input logic [0:9] c, input logic rd);
		logic [5:0] s;
		logic [3:0] f;
		logic       e;
		logic       r;
		s = c[0:5];
		f = c[6:9];
		e = 1'b0;
		r = rd;
		case ($countones(s))
			3: e = (s == SIX_ONLY_NEG && r) || (s == SIX_ONLY_POS && !r);
			4: begin e = r; r = 1'b1; end
			2: begin e = !r; r = 1'b0; end
			default: e = 1'b1;
		endcase
		case ($countones(f))
			2: e = e || (f == FOUR_ONLY_NEG && r) || (f == FOUR_ONLY_POS && !r);
			3: begin e = e || r; r = 1'b1; end
			1: begin e = e || !r; r = 1'b0; end
			default: e = 1'b1;
		endcase
		return {e, r};
	endfunction

	function automatic logic [31:0] crc32(input logic [31:0] crc, input logic [31:0] d);
		logic [31:0] c;
		c = crc;
		for (int i = 31; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ (CRC_POLY & {32{c[31] ^ d[i]}});
		return c;
	endfunction

	logic [0:9]   sh_reg;
	logic [3:0]   bit_cnt_reg;
	logic [1:0]   lane_reg;
	logic         rd_reg;
	logic [31:0]  dw_reg;
	logic [3:0]   kf_reg;
	logic         cv_reg;
	logic         push_reg;
	frame_state_t fr_reg;
	logic [31:0]  crc_reg;
	logic [31:0]  held_reg;
	logic         held_v_reg;
	logic [3:0]   widx_reg;
	logic         setup_reg;
	logic [31:0]  cap_reg;
	logic [31:0]  cnt_reg;
	logic         fifo_ready;
	logic         fifo_valid;
	logic [33:0]  fifo_out;

	// Bit a arrives first and ends up at index 0 of the character window.
	wire [0:9] sh_next = {sh_reg[1:9], bit_in};                          // see R12
	wire comma7 = (sh_next[0:6] == COMMA_NEG) || (sh_next[0:6] == COMMA_POS); // see R8 R7
	wire comma_hit = bit_valid && comma7;
	wire char_done = bit_valid && (comma7 || bit_cnt_reg == BIT_LAST);
	wire [1:0] cur_lane = comma7 ? LANE_RST : lane_reg;                    // see R11
	wire [9:0] dc = dec_char(sh_next);
	// Characters framed before a comma that moves the boundary were cut wrongly.
	// Their running disparity means nothing, so the comma's own form seeds it instead.
	wire realign = comma7 && bit_cnt_reg != BIT_LAST;                      // see R1
	wire rd_seed = realign ? (sh_next[0:5] != K28_SIX) : rd_reg;
	wire [1:0] rc = rd_check(sh_next, rd_seed);                            // see R3
	wire dc_ok = dc[9];
	wire dc_k = dc[8];                                                     // see R16
	wire [7:0] dc_byte = dc[7:0];
	wire bad_lane0 = cur_lane == LANE_RST && dc_k && dc_byte != K28_5 && dc_byte != K28_3; // see R5
	wire bad_lanex = cur_lane != LANE_RST && dc_k;                         // see R6 R13
	wire viol = !dc_ok || rc[1] || bad_lane0 || bad_lanex;                  // see R3 R4
	wire cv_next = (cur_lane == LANE_RST) ? viol : (cv_reg || viol);
	wire is_prim = kf_reg[0];
	wire is_sof = push_reg && is_prim && dw_reg == SOF_PRIM;
	wire is_eof = push_reg && is_prim && dw_reg == EOF_PRIM;
	wire is_pay = push_reg && !is_prim;
	wire [31:0] crc_fold = crc32(crc_reg, held_reg);
	wire crc_bad = held_v_reg && held_reg != crc_reg;
	wire dma_dec = dma_phase && is_pay && fr_reg == FR_BODY && held_v_reg;

	// Realignment on the comma is the only place bit times are added or removed.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sh_reg      <= '0;
			bit_cnt_reg <= BIT_RST;
			lane_reg    <= LANE_RST;
			rd_reg      <= 1'b0;
			sync_ok     <= 1'b0;
			slip_pulse  <= 1'b0;
		end
		else
		begin
			slip_pulse <= comma_hit && sync_ok && bit_cnt_reg != BIT_LAST;      // see R2 R17
			if (bit_valid)
			begin
				sh_reg      <= sh_next;
				bit_cnt_reg <= char_done ? BIT_RST : bit_cnt_reg + 4'h1;          // see R1
			end
			if (char_done)
			begin
				lane_reg <= cur_lane + 2'h1;
				rd_reg   <= rc[0];
			end
			if (comma_hit)
				sync_ok <= 1'b1;                                                 // see R11
		end
	end

	// Byte 0 sits in the low bits of the assembled Dword.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dw_reg   <= '0;
			kf_reg   <= '0;
			cv_reg   <= 1'b0;
			push_reg <= 1'b0;
		end
		else
		begin
			push_reg <= char_done && sync_ok && cur_lane == LANE_LAST;
			if (char_done)
			begin
				dw_reg[8*cur_lane +: 8] <= dc_byte;                              // see R10
				kf_reg[cur_lane]        <= dc_k;
				cv_reg                  <= cv_next;                              // see R18
			end
		end
	end

	dword_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.in_valid  (push_reg),
		.in_ready  (fifo_ready),
		.in_data   ({cv_reg, is_prim, dw_reg}),
		.out_valid (fifo_valid),
		.out_ready (out_ready),
		.out_data  (fifo_out)
	);

	assign out_valid    = fifo_valid;
	assign in_accept    = fifo_ready;
	assign out_dword    = fifo_out[31:0];
	assign out_ctrl     = fifo_out[32];
	assign out_code_err = fifo_out[33];

	// The Dword before the end primitive is the CRC and is not folded in.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fr_reg      <= FR_IDLE;
			crc_reg     <= CRC_INIT;
			held_reg    <= '0;
			held_v_reg  <= 1'b0;
			widx_reg    <= WIDX_RST;
			setup_reg   <= 1'b0;
			cap_reg     <= '0;
			frame_start <= 1'b0;
			frame_end   <= 1'b0;
			crc_err     <= 1'b0;
			frame_err   <= 1'b0;
			overflow    <= 1'b0;
		end
		else
		begin
			frame_start <= 1'b0;
			frame_end   <= 1'b0;
			crc_err     <= 1'b0;
			frame_err   <= 1'b0;
			if (push_reg && !fifo_ready)
				overflow <= 1'b1;
			case (fr_reg)
				FR_IDLE:
				begin
					if (is_sof)
					begin
						fr_reg      <= FR_BODY;                                  // see R14
						frame_start <= 1'b1;
						crc_reg     <= CRC_INIT;
						held_v_reg  <= 1'b0;
						widx_reg    <= WIDX_RST;
						setup_reg   <= 1'b0;
					end
					else if (is_eof)
						frame_err <= 1'b1;
				end
				FR_BODY:
				begin
					if (is_sof)
					begin
						frame_err  <= 1'b1;
						crc_reg    <= CRC_INIT;
						held_v_reg <= 1'b0;
						widx_reg   <= WIDX_RST;
						setup_reg  <= 1'b0;
					end
					else if (is_eof)
					begin
						fr_reg    <= FR_IDLE;
						frame_end <= 1'b1;
						crc_err   <= crc_bad || !held_v_reg;                     // see R9
					end
					else if (is_pay)
					begin
						if (held_v_reg)
							crc_reg <= crc_fold;
						held_reg   <= dw_reg;
						held_v_reg <= 1'b1;
						if (widx_reg != 4'hF)
							widx_reg <= widx_reg + 4'h1;
						if (widx_reg == WIDX_RST)
							setup_reg <= dw_reg[7:0] == DMA_SETUP_TYPE;
						if (widx_reg == COUNT_IDX)
							cap_reg <= dw_reg;
					end
				end
				default: fr_reg <= FR_IDLE;
			endcase
		end
	end

	wire dma_go = is_eof && fr_reg == FR_BODY && setup_reg && !crc_bad && held_v_reg;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dma_phase <= 1'b0;
			cnt_reg   <= '0;
		end
		else if (shadow_err)
			dma_phase <= 1'b0;                                               // see R15
		else if (dma_go)
		begin
			dma_phase <= cap_reg != '0;
			cnt_reg   <= cap_reg;
		end
		else if (dma_dec)
		begin
			cnt_reg   <= (cnt_reg > COUNT_STEP) ? cnt_reg - COUNT_STEP : '0;
			dma_phase <= cnt_reg > COUNT_STEP;                               // see R15
		end
	end

	sequence s_lane3_char;
		char_done && sync_ok && cur_lane == LANE_LAST;
	endsequence

	a_comma_realign: assert property (@(posedge mclk) disable iff (sys_rst) // see R1
		comma_hit |=> bit_cnt_reg == BIT_RST && lane_reg == 2'h1) else $error("comma did not realign");
	a_slip_comma: assert property (@(posedge mclk) disable iff (sys_rst) // see R2
		slip_pulse |-> $past(comma_hit)) else $error("slip without comma");
	a_disp_flag: assert property (@(posedge mclk) disable iff (sys_rst) // see R3
		char_done && rc[1] |=> cv_reg) else $error("disparity error not flagged");
	a_illegal_code: assert property (@(posedge mclk) disable iff (sys_rst) // see R4
		char_done && !dc_ok |=> cv_reg) else $error("illegal code not flagged");
	a_lane0_ctrl: assert property (@(posedge mclk) disable iff (sys_rst) // see R5
		char_done && bad_lane0 |=> cv_reg) else $error("bad lane 0 control not flagged");
	a_lane_ctrl: assert property (@(posedge mclk) disable iff (sys_rst) // see R6
		char_done && cur_lane != LANE_RST && dc_k |=> cv_reg) else $error("control in lane 1-3 not flagged");
	a_dword_push: assert property (@(posedge mclk) disable iff (sys_rst) // see R11
		s_lane3_char |=> push_reg ##1 !push_reg) else $error("Dword not delivered once");
	a_crc_check: assert property (@(posedge mclk) disable iff (sys_rst) // see R9
		is_eof && fr_reg == FR_BODY && crc_bad |=> crc_err && frame_end) else $error("CRC error missed");
	a_frame_open: assert property (@(posedge mclk) disable iff (sys_rst) // see R14
		is_sof && fr_reg == FR_IDLE |=> frame_start && fr_reg == FR_BODY) else $error("frame not opened");
	a_dma_stop: assert property (@(posedge mclk) disable iff (sys_rst) // see R15
		shadow_err |=> !dma_phase) else $error("DMA phase kept after error");
endmodule // serial_link_char_alignment

`default_nettype wire

// ### bench/host_link_tx.sv
// Host side transmitter model that sends 8b/10b characters one bit per clock.
`timescale 1ns/1ps
`default_nettype none

module host_link_tx (
	input  wire logic mclk,
	output logic      bit_valid,
	output logic      bit_in
);
	logic rd_reg;

	initial
	begin
		bit_valid = 1'b0;
		bit_in    = 1'b0;
		rd_reg    = 1'b0;
	end

	task automatic send_bits(input logic [9:0] code, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge mclk);
			bit_valid <= 1'b1;
			bit_in    <= code[i];
		end
	endtask

	// Data bytes use balanced sub-blocks or the unbalanced 0 forms, which follow the running disparity.
	task automatic send_char(input logic k, input logic [7:0] b);
		logic [5:0] six;
		logic [3:0] four;
		if (k)
		begin
			six    = rd_reg ? 6'b110000 : 6'b001111;
			four   = (b[7:5] == 3'h5) ? (rd_reg ? 4'b0101 : 4'b1010) : (rd_reg ? 4'b1100 : 4'b0011);
			rd_reg = ~rd_reg;
		end
		else
		begin
			case (b[4:0])
				5'h0A:   six = 6'b010101;
				5'h15:   six = 6'b101010;
				default:
				begin
					six    = rd_reg ? 6'b011000 : 6'b100111;
					rd_reg = ~rd_reg;
				end
			endcase
			case (b[7:5])
				3'h1:    four = 4'b1001;
				3'h2:    four = 4'b0101;
				3'h5:    four = 4'b1010;
				3'h6:    four = 4'b0110;
				default:
				begin
					four   = rd_reg ? 4'b0100 : 4'b1011;
					rd_reg = ~rd_reg;
				end
			endcase
		end
		send_bits({six, four}, 10);
	endtask

	task automatic send_dword(input logic [3:0] kmask, input logic [31:0] d);
		for (int n = 0; n < 4; n++)
			send_char(kmask[n], d[8*n +: 8]);
	endtask

	// The line is idle outside characters, so it shows the inverse of the last bit.
	task automatic idle();
		@(posedge mclk);
		bit_valid <= 1'b0;
		bit_in    <= ~bit_in;
	endtask
endmodule // host_link_tx

`default_nettype wire

// ### bench/testbench.sv
// Self-checking testbench of the serial link character alignment receiver.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import link_align_pkg::*;
	logic        mclk, sys_rst, shadow_err, out_ready;
	wire logic   bit_valid, bit_in;
	logic        out_valid, out_ctrl, out_code_err, in_accept, overflow, sync_ok;
	logic        slip_pulse, frame_start, frame_end, crc_err, frame_err, dma_phase;
	logic [31:0] out_dword;
	logic [33:0] got_q [$];
	int          num_errors, samples_checked, slip_n, fs_n, fe_n, ce_n, fr_n;

	host_link_tx u_host (.mclk(mclk), .bit_valid(bit_valid), .bit_in(bit_in));

	serial_link_char_alignment #(.SOF_PRIM(32'h4A4A4A7C), .EOF_PRIM(32'hB5B5B57C), .DMA_SETUP_TYPE(8'h4A),
		.COUNT_IDX(4'h0), .CRC_INIT(32'h0000004A)) u_dut (
		.mclk(mclk), .sys_rst(sys_rst), .bit_valid(bit_valid), .bit_in(bit_in), .shadow_err(shadow_err),
		.out_ready(out_ready), .out_valid(out_valid), .out_dword(out_dword), .out_ctrl(out_ctrl),
		.out_code_err(out_code_err), .in_accept(in_accept), .overflow(overflow), .sync_ok(sync_ok),
		.slip_pulse(slip_pulse), .frame_start(frame_start), .frame_end(frame_end), .crc_err(crc_err),
		.frame_err(frame_err), .dma_phase(dma_phase));

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got_q.push_back({out_code_err, out_ctrl, out_dword});
		slip_n += (slip_pulse === 1'b1);
		fs_n   += (frame_start === 1'b1);
		fe_n   += (frame_end === 1'b1);
		ce_n   += (crc_err === 1'b1);
		fr_n   += (frame_err === 1'b1);
	end

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic pop(output logic [33:0] v);
		int n;
		n = 0;
		while (got_q.size() == 0 && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
		if (got_q.size() == 0)
		begin
			num_errors++;
			conclude();
		end
		v = got_q.pop_front();
	endtask

	task automatic send_align();
		u_host.send_dword(4'h1, 32'h4A4A4ABC);
	endtask

	task automatic t_sync();
		logic [33:0] v;
		u_host.send_bits(10'h005, 3);
		repeat (4) u_host.send_char(1'b0, 8'h4A);
		u_host.idle();
		repeat (4) @(posedge mclk);
		check({33'h0, sync_ok}, 34'h0);
		check(34'(got_q.size()), 34'h0);
		send_align();
		send_align();
		u_host.send_dword(4'h0, 32'hB52AD54A);
		u_host.idle();
		pop(v);
		check(v, {2'b01, 32'h4A4A4ABC});
		pop(v);
		check(v, {2'b01, 32'h4A4A4ABC});
		pop(v);
		check(v, {2'b00, 32'hB52AD54A});
		check({33'h0, sync_ok}, 34'h1);
		check(34'(slip_n), 34'h0);
		$display("test sync done");
	endtask

	task automatic t_slip();
		logic [33:0] v;
		u_host.send_bits(10'h000, 1);
		send_align();
		u_host.send_dword(4'h0, 32'h2A2A2A2A);
		u_host.idle();
		pop(v);
		check(v, {2'b01, 32'h4A4A4ABC});
		pop(v);
		check(v, {2'b00, 32'h2A2A2A2A});
		check(34'(slip_n), 34'h1);
		$display("test slip done");
	endtask

	task automatic t_lanes();
		logic [33:0] v;
		logic [31:0] d;
		for (int n = 0; n < 4; n++)
		begin
			d = (32'h2A2A2A2A & ~(32'hFF << (8 * n))) | (32'h7C << (8 * n));
			u_host.send_dword(4'(1 << n), d);
			u_host.idle();
			pop(v);
			check(v, {n != 0, n == 0, d});
		end
		$display("test lanes done");
	endtask

	task automatic send_frame(input logic [31:0] crc);
		logic [33:0] v;
		u_host.send_dword(4'h1, 32'h4A4A4A7C);
		u_host.send_dword(4'h0, crc);
		u_host.send_dword(4'h1, 32'hB5B5B57C);
		u_host.idle();
		repeat (3) pop(v);
		repeat (3) @(posedge mclk);
	endtask

	task automatic t_frame();
		logic [33:0] v;
		send_frame(32'h0000004A);
		check(34'(fs_n), 34'h1);
		check(34'(fe_n), 34'h1);
		check(34'(ce_n), 34'h0);
		check({33'h0, dma_phase}, 34'h1);
		shadow_err <= 1'b1;
		@(posedge mclk);
		shadow_err <= 1'b0;
		@(posedge mclk);
		check({33'h0, dma_phase}, 34'h0);
		send_frame(32'h4A4A4A4A);
		check(34'(fe_n), 34'h2);
		check(34'(ce_n), 34'h1);
		u_host.send_dword(4'h1, 32'hB5B5B57C);
		u_host.idle();
		pop(v);
		repeat (3) @(posedge mclk);
		check(34'(fr_n), 34'h1);
		$display("test frame done");
	endtask

	task automatic t_fifo();
		logic [33:0] v;
		logic [7:0]  b [5] = '{8'h4A, 8'hD5, 8'h2A, 8'hB5, 8'h4A};
		out_ready <= 1'b0;
		for (int n = 0; n < 5; n++)
			u_host.send_dword(4'h0, {4{b[n]}});
		u_host.idle();
		repeat (4) @(posedge mclk);
		check({32'h0, in_accept, overflow}, 34'h1);
		out_ready <= 1'b1;
		for (int n = 0; n < 4; n++)
		begin
			pop(v);
			check(v, {2'b00, {4{b[n]}}});
		end
		repeat (4) @(posedge mclk);
		check({32'h0, out_valid, in_accept}, 34'h1);
		$display("test fifo done");
	endtask

	task automatic t_errs();
		logic [33:0] v;
		u_host.send_bits(u_host.rd_reg ? 10'h0F3 : 10'h30C, 10);
		repeat (3) u_host.send_char(1'b0, 8'h4A);
		u_host.idle();
		pop(v);
		check({33'h0, v[33]}, 34'h1);
		repeat (3) u_host.send_char(1'b0, 8'h4A);
		u_host.send_bits(10'h3CA, 10);
		u_host.idle();
		pop(v);
		check({33'h0, v[33]}, 34'h1);
		$display("test errors done");
	endtask

	initial
	begin
		sys_rst    = 1'b1;
		shadow_err = 1'b0;
		out_ready  = 1'b1;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		t_sync();
		t_slip();
		t_lanes();
		t_frame();
		t_fifo();
		t_errs();
		conclude();
	end
endmodule // testbench

`default_nettype wire
